/* File: design/wdrs_pkg.sv */
// Purpose: constants for the watchdog and reset supervisor
// Assumes: 200 MHz system clock, byte-wide register port, 4-bit address
// Notes:   a 32.768 kHz timebase tick is derived internally from clk_i
package wdrs_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [3:0] WDRS_ADDR_FLAGS = 4'h0;
  localparam logic [3:0] WDRS_ADDR_WDOG  = 4'h7;
  localparam logic [3:0] WDRS_ADDR_WDAY  = 4'hc;

  // field positions
  localparam int WDRS_FLAG_EXP_BIT  = 7;
  localparam int WDRS_WD_STEER_BIT  = 7;
  localparam int WDRS_WD_MULT_LSB   = 2;
  localparam int WDRS_WD_RES_LSB    = 0;
  localparam int WDRS_DAY_FT_BIT    = 6;
  localparam logic [7:0] WDRS_WDAY_MASK = 8'h47;  // writable bits of weekday reg

  // reset values
  localparam logic [7:0] WDRS_WDOG_RST = 8'h00;
  localparam logic [7:0] WDRS_WDAY_RST = 8'h00;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ         = 200_000_000;
  localparam int TB_HZ          = 32_768;
  // 200e6/32768 = 6103.5; rounded down so a tick is never slower
  localparam int TB_DIV         = CLK_HZ / TB_HZ;
  // 1/16 s at 32768 Hz
  localparam int RES_UNIT_TICKS = TB_HZ / 16;
  localparam int RST_PULSE_MS   = 100;            // inside 40..200 ms
  localparam int RST_PULSE_TB   = (TB_HZ * RST_PULSE_MS) / 1000;
  localparam int REQA_MIN_NS    = 200;
  localparam int REQA_REJ_NS    = 50;
  // accept point between reject and minimum: 125 ns
  localparam int REQA_CYC       = ((REQA_MIN_NS + REQA_REJ_NS) / 2 * (CLK_HZ / 1_000_000)) / 1000;
  localparam int REQB_MIN_MS    = 100;
  localparam int REQB_REJ_MS    = 20;
  // accept point 60 ms, counted in timebase ticks
  localparam int REQB_TB        = (TB_HZ * ((REQB_MIN_MS + REQB_REJ_MS) / 2)) / 1000;

endpackage : wdrs_pkg

/* File: design/wdrs_lowfilt.sv */
// Purpose: low-level qualifier for an active-low request input
// Assumes: input synchronous to clk_i; count advances on en_i
// Notes:   fires one pulse once the input has stayed low for LIMIT steps
`timescale 1ns/100ps
`default_nettype none
module wdrs_lowfilt #(
  parameter int LIMIT = 20,
  parameter int CW    = 24
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // step enable and input
  input  wire logic en_i,
  input  wire logic req_n_i,
  input  wire logic hold_i,
  // qualified request
  output logic      fire_o
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          fire_ff;
  logic          nxt_fire;

  // any high level restarts the count, so short glitches never accumulate
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_fire = 1'b0;
    if (req_n_i || hold_i) begin
      nxt_cnt = '0;
    end else if (en_i && (cnt_ff != CW'(LIMIT))) begin
      nxt_cnt = cnt_ff + 1'b1;
      if (cnt_ff == CW'(LIMIT - 1)) begin
        nxt_fire = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      fire_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      fire_ff <= nxt_fire;
    end
  end

  assign fire_o = fire_ff;

endmodule : wdrs_lowfilt
`default_nettype wire

/* File: design/wdrs_top.sv */
// Purpose: watchdog timer and reset supervisor with byte-wide register port
// Assumes: all inputs synchronous to clk_i; power_ok_i high above threshold
// Notes:   open-drain outputs given as drive-low enables
`timescale 1ns/100ps
`default_nettype none
module wdrs_top #(
  parameter int TB_DIV_P  = wdrs_pkg::TB_DIV,
  parameter int RST_TB_P  = wdrs_pkg::RST_PULSE_TB,
  parameter int REQB_TB_P = wdrs_pkg::REQB_TB,
  parameter int UNIT_P    = wdrs_pkg::RES_UNIT_TICKS
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic       cs_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // supervision inputs
  input  wire logic       power_ok_i,
  input  wire logic       watchdog_kick_in_i,
  input  wire logic       reset_request_a_n_i,
  input  wire logic       reset_request_b_n_i,
  input  wire logic       freq_wave_i,
  // outputs; an oe enable high means pin pulled low, reset_out_n_o is low while reset is out
  output logic            interrupt_or_freqtest_out_oe_o,
  output logic            reset_out_oe_o,
  output logic            reset_out_n_o
);
  import wdrs_pkg::*;

  // --------------------------------------------------------------------------
  // timebase
  // --------------------------------------------------------------------------
  logic [12:0] div_ff, nxt_div;
  logic        tick_ff, nxt_tick;

  // one tick per 32.768 kHz period drives every slow count
  always_comb begin
    nxt_div  = div_ff + 13'h1;
    nxt_tick = 1'b0;
    if (div_ff == 13'(TB_DIV_P - 1)) begin
      nxt_div  = 13'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= 13'h0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // --------------------------------------------------------------------------
  // reset requests
  // --------------------------------------------------------------------------
  logic rst_busy_ff;
  logic fire_a;
  logic fire_b;

  wdrs_lowfilt #(.LIMIT(REQA_CYC), .CW(8)) u_filt_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (1'b1),
    .req_n_i (reset_request_a_n_i),
    .hold_i  (rst_busy_ff),
    .fire_o  (fire_a)
  );

  wdrs_lowfilt #(.LIMIT(REQB_TB_P), .CW(16)) u_filt_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (tick_ff),
    .req_n_i (reset_request_b_n_i),
    .hold_i  (rst_busy_ff),
    .fire_o  (fire_b)
  );

  // --------------------------------------------------------------------------
  // registers and watchdog
  // --------------------------------------------------------------------------
  logic [7:0]  wdog_ff, nxt_wdog;
  logic [7:0]  wday_ff, nxt_wday;
  logic        exp_flag_ff, nxt_exp_flag;
  logic        irq_ff, nxt_irq;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [16:0] cnt_ff, nxt_cnt;
  logic [17:0] unit_ff, nxt_unit;
  logic        kick_ff;
  logic        wd_expire;

  // the 4 s unit at the real rate needs 18 bits; 16 would wrap to zero
  function automatic logic [17:0] unit_ticks(input logic [1:0] res);
    unit_ticks = 18'(UNIT_P) << {res, 1'b0};
  endfunction : unit_ticks

  wire [4:0] mult    = wdog_ff[WDRS_WD_MULT_LSB +: 5];
  wire [1:0] res     = wdog_ff[WDRS_WD_RES_LSB +: 2];
  wire       steer   = wdog_ff[WDRS_WD_STEER_BIT];
  wire       wr_wdog = cs_i && wr_i && (addr_i == WDRS_ADDR_WDOG);
  wire       wr_wday = cs_i && wr_i && (addr_i == WDRS_ADDR_WDAY);
  wire       rd_flag = cs_i && rd_i && (addr_i == WDRS_ADDR_FLAGS);
  wire       kick    = watchdog_kick_in_i ^ kick_ff;
  wire       wd_on   = (mult != 5'h0) && power_ok_i;

  assign wd_expire = wd_on && tick_ff && (cnt_ff == 17'h0) &&
                     (unit_ff == 18'h1) && !wr_wdog && !kick;

  // countdown in resolution units; sub-unit prescaler is restarted too,
  // so the error stays below one unit
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_unit = unit_ff;
    if (!wd_on || wr_wdog || kick) begin
      nxt_cnt  = 17'({wr_wdog ? wdata_i[6:2] : mult});
      nxt_unit = unit_ticks(wr_wdog ? wdata_i[1:0] : res);
      nxt_cnt  = nxt_cnt - 17'h1;
    end else if (tick_ff) begin
      if (unit_ff <= 18'h1) begin
        nxt_unit = unit_ticks(res);
        if (cnt_ff != 17'h0) begin
          nxt_cnt = cnt_ff - 17'h1;
        end else begin
          nxt_cnt = 17'(mult) - 17'h1;
        end
      end else begin
        nxt_unit = unit_ff - 18'h1;
      end
    end
  end

  // register file, flags and interrupt
  always_comb begin
    nxt_wdog     = wdog_ff;
    nxt_wday     = wday_ff;
    nxt_exp_flag = exp_flag_ff;
    nxt_irq      = irq_ff;
    if (wr_wdog) begin
      nxt_wdog = wdata_i;
      if (wdata_i == 8'h00) begin
        nxt_irq = 1'b0;
      end
    end
    if (wr_wday) begin
      nxt_wday = wdata_i & WDRS_WDAY_MASK;
    end
    if (rd_flag) begin
      nxt_exp_flag = 1'b0;
    end
    if (wd_expire) begin
      nxt_exp_flag = 1'b1;
      if (steer) begin
        nxt_wdog = WDRS_WDOG_RST;
        nxt_wday[WDRS_DAY_FT_BIT] = 1'b0;
      end else begin
        nxt_irq = 1'b1;
      end
    end
    if (!power_ok_i) begin
      nxt_wdog = WDRS_WDOG_RST;
      nxt_irq  = 1'b0;
    end
  end

  // read data; bits nobody owns read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (cs_i && rd_i) begin
      case (addr_i)
        WDRS_ADDR_FLAGS: nxt_rdata[WDRS_FLAG_EXP_BIT] = exp_flag_ff;
        WDRS_ADDR_WDOG:  nxt_rdata = wdog_ff;
        WDRS_ADDR_WDAY:  nxt_rdata = wday_ff;
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_ff     <= WDRS_WDOG_RST;
      wday_ff     <= WDRS_WDAY_RST;
      exp_flag_ff <= 1'b0;
      irq_ff      <= 1'b0;
      rdata_ff    <= 8'h00;
      cnt_ff      <= 17'h0;
      unit_ff     <= 18'h0;
      kick_ff     <= 1'b0;
    end else begin
      wdog_ff     <= nxt_wdog;
      wday_ff     <= nxt_wday;
      exp_flag_ff <= nxt_exp_flag;
      irq_ff      <= nxt_irq;
      rdata_ff    <= nxt_rdata;
      cnt_ff      <= nxt_cnt;
      unit_ff     <= nxt_unit;
      kick_ff     <= watchdog_kick_in_i;
    end
  end

  // --------------------------------------------------------------------------
  // reset output sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WDRS_IDLE = 2'b00,
    WDRS_HOLD = 2'b01,
    WDRS_TIME = 2'b11
  } wdrs_state_t;

  wdrs_state_t state_ff, nxt_state;
  logic [15:0] rcnt_ff, nxt_rcnt;
  logic        nxt_busy;
  logic        oe_ff, nxt_oe;
  logic        rst_n_ff;     // pin level kept in its own flop, no gate after it

  // hold while supply is down, then time a fixed pulse after recovery
  always_comb begin
    nxt_state = state_ff;
    nxt_rcnt  = rcnt_ff;
    case (state_ff)
      WDRS_IDLE: begin
        if (!power_ok_i) begin
          nxt_state = WDRS_HOLD;
        end else if (fire_a || fire_b || (wd_expire && steer)) begin
          nxt_state = WDRS_TIME;
          nxt_rcnt  = 16'(RST_TB_P);
        end
      end
      WDRS_HOLD: begin
        if (power_ok_i) begin
          nxt_state = WDRS_TIME;
          nxt_rcnt  = 16'(RST_TB_P);
        end
      end
      WDRS_TIME: begin
        if (!power_ok_i) begin
          nxt_state = WDRS_HOLD;
        end else if (tick_ff) begin
          if (rcnt_ff <= 16'h1) begin
            nxt_state = WDRS_IDLE;
          end else begin
            nxt_rcnt = rcnt_ff - 16'h1;
          end
        end
      end
      default: nxt_state = WDRS_HOLD;
    endcase
    nxt_busy = (nxt_state != WDRS_IDLE);
  end

  // watchdog interrupt wins; the test wave only shows when nothing else does
  always_comb begin
    nxt_oe = irq_ff;
    if (!irq_ff && wday_ff[WDRS_DAY_FT_BIT] && power_ok_i &&
        (steer || (wdog_ff == 8'h00))) begin
      nxt_oe = !freq_wave_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= WDRS_TIME;
      rcnt_ff     <= 16'(RST_TB_P);
      rst_busy_ff <= 1'b1;
      rst_n_ff    <= 1'b0;
      oe_ff       <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      rcnt_ff     <= nxt_rcnt;
      rst_busy_ff <= nxt_busy;
      rst_n_ff    <= !nxt_busy;
      oe_ff       <= nxt_oe;
    end
  end

  assign rdata_o                        = rdata_ff;
  assign interrupt_or_freqtest_out_oe_o = oe_ff;
  assign reset_out_oe_o                 = rst_busy_ff;
  assign reset_out_n_o                  = rst_n_ff;

endmodule : wdrs_top
`default_nettype wire

/* File: bench/wdrs_asserts.sv */
// Purpose: port-level checks for wdrs_top
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every wdrs_top instance below
`timescale 1ns/100ps
`default_nettype none
module wdrs_asserts (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic       cs_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] rdata_o,
  // supervision
  input  wire logic       power_ok_i,
  input  wire logic       reset_out_oe_o,
  input  wire logic       reset_out_n_o,
  input  wire logic       interrupt_or_freqtest_out_oe_o
);
  import wdrs_pkg::*;
  // --------------------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_s(a); cs_i && wr_i && !rd_i && addr_i == a; endsequence
  sequence rd_s(a); cs_i && rd_i && !wr_i && addr_i == a; endsequence
  // reset must win even while reset is asserted, so no disable here
  hold_in_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> reset_out_oe_o && !interrupt_or_freqtest_out_oe_o) else $error("reset state");
  post_reset_hold_a: assert property ($fell(rst_i) |-> reset_out_oe_o [*8])
    else $error("reset released early");
  power_fail_a: assert property (!power_ok_i |-> ##[0:2] reset_out_oe_o)
    else $error("no reset on power fail");
  inv_out_a: assert property (reset_out_n_o != reset_out_oe_o)
    else $error("reset pin pair disagree");
  pulse_len_a: assert property ($rose(reset_out_oe_o) |-> reset_out_oe_o [*8])
    else $error("reset pulse short");
  wd_readback_a: assert property (wr_s(WDRS_ADDR_WDOG) ##2 rd_s(WDRS_ADDR_WDOG)
    |=> rdata_o == $past(wdata_i, 3)) else $error("watchdog readback");
  wday_mask_a: assert property (wr_s(WDRS_ADDR_WDAY) ##2 rd_s(WDRS_ADDR_WDAY)
    |=> rdata_o == ($past(wdata_i, 3) & WDRS_WDAY_MASK)) else $error("weekday readback");
  unmapped_zero_a: assert property (cs_i && rd_i && !(addr_i inside {4'h0, 4'h7, 4'hc})
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule : wdrs_asserts
bind wdrs_top wdrs_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i), .rd_i(rd_i),
  .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .power_ok_i(power_ok_i), .reset_out_oe_o(reset_out_oe_o), .reset_out_n_o(reset_out_n_o),
  .interrupt_or_freqtest_out_oe_o(interrupt_or_freqtest_out_oe_o));
`default_nettype wire

/* File: bench/wdrs_pins_model.sv */
// Purpose: far-side pins: supply, kick source, request lines
// Assumes: bench commands change at the falling edge
// Notes:   request lines idle high, as through a pull-up
`timescale 1ns/100ps
`default_nettype none
module wdrs_pins_model (
  // clock and commands
  input  wire logic clk_i,
  input  wire logic kick_i,
  input  wire logic req_a_i,
  input  wire logic req_b_i,
  input  wire logic pfail_i,
  // pins
  output logic      kick_o,
  output logic      req_a_n_o,
  output logic      req_b_n_o,
  output logic      power_ok_o
);
  // supply good and requests released from time zero
  logic kick_ff  = 1'b0;
  logic req_a_ff = 1'b0;
  logic req_b_ff = 1'b0;
  logic pfail_ff = 1'b0;
  // one command cycle gives one edge or one low cycle
  always @(negedge clk_i) begin
    kick_ff  <= kick_ff ^ kick_i;
    req_a_ff <= req_a_i;
    req_b_ff <= req_b_i;
    pfail_ff <= pfail_i;
  end
  // request lines sit high through their pull-ups when released
  assign kick_o     = kick_ff;
  assign req_a_n_o  = !req_a_ff;
  assign req_b_n_o  = !req_b_ff;
  assign power_ok_o = !pfail_ff;
endmodule : wdrs_pins_model
`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: directed test of the watchdog and reset supervisor
// Assumes: shortened timebase: 4 clks a tick, 2 ticks a 1/16 unit
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import wdrs_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cs_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, freq_wave_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       kick_c = 1'b0, ra_c = 1'b0, rb_c = 1'b0, pf_c = 1'b0;
  logic       kick, ra_n, rb_n, pok, irq, ro_oe, ro_n;
  logic [7:0] rdata_o, d;
  int         n, u, checked = 0, miscompares = 0;
  always #2.5 clk_i = ~clk_i;
  wdrs_pins_model i_pins (.clk_i(clk_i), .kick_i(kick_c), .req_a_i(ra_c), .req_b_i(rb_c),
    .pfail_i(pf_c), .kick_o(kick), .req_a_n_o(ra_n), .req_b_n_o(rb_n), .power_ok_o(pok));
  wdrs_top #(.TB_DIV_P(4), .RST_TB_P(5), .REQB_TB_P(3), .UNIT_P(2)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .power_ok_i(pok), .watchdog_kick_in_i(kick),
    .reset_request_a_n_i(ra_n), .reset_request_b_n_i(rb_n), .freq_wave_i(freq_wave_i),
    .interrupt_or_freqtest_out_oe_o(irq), .reset_out_oe_o(ro_oe), .reset_out_n_o(ro_n));
  // --------------------------------------------------------------------------
  // register port tasks; released lines show inverted values
  // --------------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk_i);
    {cs_i, wr_i, addr_i, wdata_i} <= {2'b11, a, v};
    @(negedge clk_i);
    {cs_i, wr_i, addr_i, wdata_i} <= {2'b00, ~a, ~v};
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge clk_i);
    {cs_i, rd_i, addr_i} <= {2'b11, a};
    @(negedge clk_i);
    v = rdata_o;
    {cs_i, rd_i, addr_i} <= {2'b00, ~a};
  endtask : rd
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // bounded wait on the reset (r=1) or interrupt pin enable
  task automatic wait_sig(input bit r, input logic v, input int lim, output int k);
    k = 0;
    while (((r ? ro_oe : irq) !== v) && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_sig
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i <= 1'b0;
    wait_sig(1, 1'b0, 200, n);
    `CHK(n > 12, 1'b1)
    rd(WDRS_ADDR_WDOG, d);
    `CHK(d, 8'h00)
    rd(WDRS_ADDR_WDAY, d);
    `CHK(d, 8'h00)
    rd(4'h5, d);
    // write then read back two cycles later, weekday bits masked
    wr(WDRS_ADDR_WDAY, 8'hbf);
    rd(WDRS_ADDR_WDAY, d);
    `CHK(d, 8'h07)
    wr(WDRS_ADDR_WDOG, 8'h83);
    rd(WDRS_ADDR_WDOG, d);
    `CHK(d, 8'h83)
    // every resolution code, multiplier 2, interrupt steering
    for (int r = 0; r < 4; r++) begin
      wr(WDRS_ADDR_WDOG, {1'b0, 5'd2, r[1:0]});
      wait_sig(0, 1'b1, 4000, n);
      u = 8 * (4 ** r);
      `CHK((n >= u - 2) && (n <= 3 * u + 4), 1'b1)
      rd(WDRS_ADDR_FLAGS, d);
      `CHK(d[7], 1'b1)
      rd(WDRS_ADDR_FLAGS, d);
      `CHK(d[7], 1'b0)
      wr(WDRS_ADDR_WDOG, 8'h00);
      repeat (2) @(negedge clk_i);
      `CHK(irq, 1'b0)
    end
    // kicks and rewrites hold off a 32-clock timeout
    wr(WDRS_ADDR_WDOG, 8'h10);
    for (int i = 0; i < 12; i++) begin
      repeat (6) @(negedge clk_i);
      if (i[0]) wr(WDRS_ADDR_WDOG, 8'h10);
      else begin
        kick_c <= 1'b1;
        @(negedge clk_i);
        kick_c <= 1'b0;
        @(negedge clk_i);
      end
      `CHK(irq, 1'b0)
    end
    wait_sig(0, 1'b1, 200, n);
    `CHK(n >= 20, 1'b1)
    rd(WDRS_ADDR_FLAGS, d);
    wr(WDRS_ADDR_WDOG, 8'h00);
    // zero multiplier never expires
    wr(WDRS_ADDR_WDOG, 8'h83);
    repeat (600) @(negedge clk_i);
    `CHK({ro_oe, irq}, 2'b00)
    rd(WDRS_ADDR_FLAGS, d);
    `CHK(d[7], 1'b0)
    // reset steering clears the register and the test enable
    wr(WDRS_ADDR_WDAY, 8'h45);
    wr(WDRS_ADDR_WDOG, 8'h84);
    wait_sig(1, 1'b1, 100, n);
    wait_sig(1, 1'b0, 100, n);
    `CHK((n >= 8) && (n <= 40), 1'b1)
    rd(WDRS_ADDR_WDOG, d);
    `CHK(d, 8'h00)
    rd(WDRS_ADDR_WDAY, d);
    `CHK(d, 8'h05)
    rd(WDRS_ADDR_FLAGS, d);
    `CHK(d[7], 1'b1)
    // test waveform only when the watchdog does not own the pin
    freq_wave_i <= 1'b0;
    wr(WDRS_ADDR_WDAY, 8'h40);
    repeat (2) @(negedge clk_i);
    `CHK(irq, 1'b1)
    wr(WDRS_ADDR_WDOG, 8'h08);
    repeat (2) @(negedge clk_i);
    `CHK(irq, 1'b0)
    wait_sig(0, 1'b1, 100, n);
    freq_wave_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK(irq, 1'b1)
    wr(WDRS_ADDR_WDOG, 8'h00);
    repeat (2) @(negedge clk_i);
    `CHK(irq, 1'b0)
    wr(WDRS_ADDR_WDAY, 8'h00);
    // short request pulses are noise
    ra_c <= 1'b1;
    repeat (10) @(negedge clk_i);
    ra_c <= 1'b0;
    rb_c <= 1'b1;
    repeat (2) @(negedge clk_i);
    rb_c <= 1'b0;
    repeat (40) @(negedge clk_i);
    `CHK(ro_oe, 1'b0)
    // request a, then both held low while reset is out
    ra_c <= 1'b1;
    wait_sig(1, 1'b1, 60, n);
    `CHK((n >= 18) && (n <= 30), 1'b1)
    rb_c <= 1'b1;
    repeat (15) @(negedge clk_i);
    ra_c <= 1'b0;
    rb_c <= 1'b0;
    wait_sig(1, 1'b0, 100, n);
    repeat (60) @(negedge clk_i);
    `CHK(ro_oe, 1'b0)
    // request b qualified after its count of 3 timebase ticks
    rb_c <= 1'b1;
    wait_sig(1, 1'b1, 80, n);
    `CHK(n >= 8, 1'b1)
    rb_c <= 1'b0;
    wait_sig(1, 1'b0, 100, n);
    `CHK(n >= 12, 1'b1)
    // power fail clears an armed watchdog
    wr(WDRS_ADDR_WDOG, 8'h9f);
    pf_c <= 1'b1;
    repeat (10) @(negedge clk_i);
    `CHK(ro_oe, 1'b1)
    pf_c <= 1'b0;
    wait_sig(1, 1'b0, 100, n);
    `CHK(n >= 12, 1'b1)
    rd(WDRS_ADDR_WDOG, d);
    `CHK(d, 8'h00)
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
